// file: hdl/ulsr_defines.vh
// Register indices, field positions and reset values of the link slice.
`ifndef ULSR_DEFINES_VH
`define ULSR_DEFINES_VH

`define ULSR_ADDR_W 12
`define ULSR_IDX_FLAGS 5'h0A
`define ULSR_IDX_ENABLES 5'h0B
`define ULSR_IDX_FRAME 5'h0C
`define ULSR_IDX_SELECT 5'h0E
`define ULSR_IDX_TEST 5'h0F
`define ULSR_IDX_IN_SIZE 5'h10
`define ULSR_IDX_IN_CTRL_LO 5'h12
`define ULSR_IDX_IN_CTRL_HI 5'h13
`define ULSR_IDX_OUT_SIZE 5'h14
`define ULSR_IDX_OUT_CTRL_LO 5'h16
`define ULSR_IDX_OUT_CTRL_HI 5'h17
`define ULSR_IDX_OUT_COUNT 5'h18

`define ULSR_SLOT_COUNT 3'h6
`define ULSR_SLOT_NONE 4'hF

`define ULSR_FLAG_SUSPEND 0
`define ULSR_FLAG_RESUME 1
`define ULSR_FLAG_RESET 2
`define ULSR_FLAG_SOF 3

`define ULSR_ENABLES_RST 9'h006
`define ULSR_TEST_RST 9'h000
`define ULSR_SELECT_RST 8'h00

`define ULSR_TEST_NAK 0
`define ULSR_TEST_J 1
`define ULSR_TEST_K 2
`define ULSR_TEST_PACKET 3
`define ULSR_TEST_HS_LOCK 4
`define ULSR_TEST_FS_LOCK 5

`define ULSR_EP_FIRST 5'h01
`define ULSR_EP_LAST 5'h0B

`define ULSR_PID_DATA0 8'hC3
`define ULSR_PKT_LEN 6'h35
`define ULSR_CRC_INIT 16'hFFFF
`define ULSR_CRC_POLY 16'hA001

`endif

// file: hdl/ulsr_ep_bank.v
// Banked per-endpoint registers for endpoints 0 to 15; ulsr_top limits software access to endpoints 1 to 11.
`timescale 1ns/1ns
`include "ulsr_defines.vh"

module ulsr_ep_bank (
	input wire pclk,
	input wire presetn,
	input wire sw_we,
	input wire [3:0] sw_ep,
	input wire [2:0] sw_slot,
	input wire [15:0] sw_wdata,
	output wire [15:0] sw_rdata,
	input wire hw_we,
	input wire [3:0] hw_ep,
	input wire [15:0] hw_count
);

	// ---------------------------------------------------------------
	// Storage
	// ---------------------------------------------------------------
	// One word per endpoint and slot; the byte count slot is loaded
	// by the receive side only.
	reg [15:0] bank_q [0:127];
	integer i;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (i = 0; i < 128; i = i + 1) begin
				bank_q[i] <= 16'h0000;
			end
		end else begin
			if (sw_we && sw_slot != `ULSR_SLOT_COUNT) begin
				bank_q[{sw_ep, sw_slot}] <= sw_wdata; // [R6]
			end
			if (hw_we) begin
				bank_q[{hw_ep, `ULSR_SLOT_COUNT}] <= hw_count;
			end
		end
	end

	assign sw_rdata = bank_q[{sw_ep, sw_slot}]; // [R6]

endmodule // ulsr_ep_bank

// file: hdl/ulsr_test_tx.v
// Repeating test packet sender fed from the endpoint 0 buffer.
`timescale 1ns/1ns
`include "ulsr_defines.vh"

module ulsr_test_tx (
	input wire pclk,
	input wire presetn,
	input wire enable,
	input wire [7:0] ep0_rd_data,
	output wire [5:0] ep0_rd_addr,
	output wire tx_valid,
	input wire tx_ready,
	output wire [7:0] tx_data
);

	localparam [4:0] S_IDLE = 5'h01;
	localparam [4:0] S_PID = 5'h02;
	localparam [4:0] S_DATA = 5'h04;
	localparam [4:0] S_CRCL = 5'h08;
	localparam [4:0] S_CRCH = 5'h10;

	// ---------------------------------------------------------------
	// CRC over one byte, least significant bit first
	// ---------------------------------------------------------------
	function [15:0] ulsr_crc_byte;
		input [15:0] crc;
		input [7:0] data;
		integer b;
		reg [15:0] c;
		begin
			c = crc;
			for (b = 0; b < 8; b = b + 1) begin
				if (c[0] ^ data[b]) begin
					c = (c >> 1) ^ `ULSR_CRC_POLY;
				end else begin
					c = c >> 1;
				end
			end
			ulsr_crc_byte = c;
		end
	endfunction

	reg [4:0] state_q;
	reg [7:0] byte_q;
	reg [5:0] addr_q;
	reg [15:0] crc_q;
	wire take;
	wire [15:0] crc_next;

	assign take = tx_ready && state_q != S_IDLE;
	assign crc_next = ulsr_crc_byte(crc_q, byte_q);
	assign tx_valid = state_q != S_IDLE;
	assign tx_data = byte_q;
	assign ep0_rd_addr = addr_q;

	// ---------------------------------------------------------------
	// Packet sequencer
	// ---------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= S_IDLE;
			byte_q <= 8'h00;
			addr_q <= 6'h00;
			crc_q <= `ULSR_CRC_INIT;
		end else begin
			case (state_q)
			S_IDLE: begin
				if (enable) begin
					state_q <= S_PID;
					byte_q <= `ULSR_PID_DATA0; // [R10]
					addr_q <= 6'h00;
				end
			end
			S_PID: begin
				if (take) begin
					state_q <= S_DATA;
					byte_q <= ep0_rd_data;
					addr_q <= 6'h01;
					crc_q <= `ULSR_CRC_INIT;
				end
			end
			S_DATA: begin
				if (take) begin
					crc_q <= crc_next;
					if (addr_q == `ULSR_PKT_LEN) begin
						state_q <= S_CRCL;
						byte_q <= ~crc_next[7:0]; // [R10]
					end else begin
						byte_q <= ep0_rd_data;
						addr_q <= addr_q + 6'h01;
					end
				end
			end
			S_CRCL: begin
				if (take) begin
					state_q <= S_CRCH;
					byte_q <= ~crc_q[15:8]; // [R10]
				end
			end
			S_CRCH: begin
				if (take) begin
					if (enable) begin
						state_q <= S_PID; // [R11]
						byte_q <= `ULSR_PID_DATA0;
						addr_q <= 6'h00;
					end else begin
						state_q <= S_IDLE;
					end
				end
			end
			default: begin
				state_q <= S_IDLE;
			end
			endcase
		end
	end

endmodule // ulsr_test_tx

// file: hdl/ulsr_top.v
// Link event registers, endpoint bank select and compliance test modes.
//
// How it works
// R1 - Flag bit 0 mirrors link suspended state.
// R2 - SOF bit 3, suspend bit 0 enables reset 0.
// R3 - Bus reset and resume enables reset to 1.
// R4 - Last SOF frame number in 10:0; rest zero.
// R5 - Five-bit endpoint selector, reset zero, picks bank.
// R6 - Endpoints 1 to 11 have own banked registers.
// R7 - Full-speed lock: bus reset forces full speed.
// R8 - High-speed lock: bus reset forces high speed.
// R9 - Software loads packet, arms endpoint, then sets mode.
// R10 - Test packet gets DATA0 PID and CRC.
// R11 - Test packet repeats until mode bit cleared.
// R12 - K test bit drives continuous K state.
// R13 - J test bit drives continuous J state.
// R14 - NAK-only mode NAKs every valid IN token.
// R15 - Resume, bus reset and SOF set sticky flags; resume sets its flag only while link suspended.
// R16 - Interrupt when enabled flag condition present.
// R17 - Software sets one test bit, keeps reserved.
//
// The APB slave port was decided locally.
`timescale 1ns/1ns
`include "ulsr_defines.vh"

module ulsr_top (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`ULSR_ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire link_suspended,
	input wire link_resume_det,
	input wire link_bus_reset,
	input wire link_sof,
	input wire [10:0] link_sof_frame,
	input wire link_chirp_done,
	input wire link_chirp_hs,
	input wire link_in_token,
	input wire rx_count_we,
	input wire [3:0] rx_count_ep,
	input wire [15:0] rx_count,
	input wire [7:0] ep0_rd_data,
	output wire [5:0] ep0_rd_addr,
	output wire tx_valid,
	input wire tx_ready,
	output wire [7:0] tx_data,
	output wire sig_irq,
	output wire speed_hs,
	output wire chirp_enable,
	output wire nak_resp,
	output wire line_j,
	output wire line_k
);

	// ---------------------------------------------------------------
	// Address decode helpers
	// ---------------------------------------------------------------
	// Returns the word index of an aligned address, or all ones when
	// the address is misaligned or at 0x080 or above.
	function [4:0] ulsr_index;
		input [`ULSR_ADDR_W-1:0] addr;
		begin
			if (addr[1:0] != 2'b00 || addr[`ULSR_ADDR_W-1:7] != 5'h00) begin
				ulsr_index = 5'h1F;
			end else begin
				ulsr_index = addr[6:2];
			end
		end
	endfunction

	// Maps a banked register index onto its storage slot.
	function [3:0] ulsr_slot;
		input [4:0] idx;
		begin
			case (idx)
			`ULSR_IDX_IN_SIZE: ulsr_slot = 4'h0;
			`ULSR_IDX_IN_CTRL_LO: ulsr_slot = 4'h1;
			`ULSR_IDX_IN_CTRL_HI: ulsr_slot = 4'h2;
			`ULSR_IDX_OUT_SIZE: ulsr_slot = 4'h3;
			`ULSR_IDX_OUT_CTRL_LO: ulsr_slot = 4'h4;
			`ULSR_IDX_OUT_CTRL_HI: ulsr_slot = 4'h5;
			`ULSR_IDX_OUT_COUNT: ulsr_slot = 4'h6;
			default: ulsr_slot = `ULSR_SLOT_NONE;
			endcase
		end
	endfunction

	// ---------------------------------------------------------------
	// Registers and decode
	// ---------------------------------------------------------------
	reg [3:1] flags_q;
	reg [3:1] flags_d;
	reg [8:0] enables_q;
	reg [10:0] frame_q;
	reg [7:0] select_q;
	reg [8:0] test_q;
	reg speed_hs_q;
	reg chirp_q;
	reg nak_q;
	reg line_j_q;
	reg line_k_q;

	wire [4:0] idx;
	wire [3:0] slot;
	wire bank_hit;
	wire ep_valid;
	wire addr_hit;
	wire wr_acc;
	wire rd_acc;
	wire setup;
	wire [15:0] bank_rdata;
	wire [8:0] flags_all;

	assign idx = ulsr_index(paddr);
	assign slot = ulsr_slot(idx);
	assign bank_hit = slot != `ULSR_SLOT_NONE;
	assign ep_valid = select_q[4:0] >= `ULSR_EP_FIRST &&
		select_q[4:0] <= `ULSR_EP_LAST; // [R6]
	assign addr_hit = bank_hit || idx == `ULSR_IDX_FLAGS ||
		idx == `ULSR_IDX_ENABLES || idx == `ULSR_IDX_FRAME ||
		idx == `ULSR_IDX_SELECT || idx == `ULSR_IDX_TEST;
	assign setup = psel && !penable;
	assign wr_acc = psel && penable && pwrite && addr_hit;
	assign rd_acc = psel && penable && !pwrite && addr_hit;

	// The slave always answers in the first access cycle.
	assign pready = 1'b1;
	// Unmapped or misaligned accesses end with an error.
	assign pslverr = psel && penable && !addr_hit;

	assign flags_all = {5'h00, flags_q, link_suspended}; // [R1]

	// ---------------------------------------------------------------
	// Read data, captured in the setup cycle
	// ---------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (setup && !pwrite) begin
			case (idx)
			`ULSR_IDX_FLAGS: prdata <= {23'h000000, flags_all};
			`ULSR_IDX_ENABLES: prdata <= {23'h000000, enables_q};
			`ULSR_IDX_FRAME: prdata <= {21'h000000, frame_q}; // [R4]
			`ULSR_IDX_SELECT: prdata <= {24'h000000, select_q};
			`ULSR_IDX_TEST: prdata <= {23'h000000, test_q};
			default: begin
				if (bank_hit && ep_valid) begin
					prdata <= {16'h0000, bank_rdata}; // [R5]
				end else begin
					prdata <= 32'h00000000;
				end
			end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Sticky event flags, cleared by reading them
	// ---------------------------------------------------------------
	always @* begin
		flags_d = flags_q;
		// Only the flags that the read returned are cleared, so an
		// event landing between capture and clear survives.
		if (rd_acc && idx == `ULSR_IDX_FLAGS) begin
			flags_d = flags_q & ~prdata[3:1];
		end
		// A new event in the clearing cycle is kept.
		if (link_resume_det && link_suspended) begin
			flags_d[`ULSR_FLAG_RESUME] = 1'b1; // [R15]
		end
		if (link_bus_reset) begin
			flags_d[`ULSR_FLAG_RESET] = 1'b1; // [R15]
		end
		if (link_sof) begin
			flags_d[`ULSR_FLAG_SOF] = 1'b1; // [R15]
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_q <= 3'b000;
		end else begin
			flags_q <= flags_d;
		end
	end

	assign sig_irq = |(flags_all & enables_q[8:0]); // [R16]

	// ---------------------------------------------------------------
	// Software written registers
	// ---------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enables_q <= `ULSR_ENABLES_RST; // [R2] [R3]
			select_q <= `ULSR_SELECT_RST; // [R5]
			test_q <= `ULSR_TEST_RST;
		end else if (wr_acc) begin
			if (idx == `ULSR_IDX_ENABLES) begin
				enables_q <= pwdata[8:0]; // [R2] [R3]
			end
			if (idx == `ULSR_IDX_SELECT) begin
				select_q <= pwdata[7:0]; // [R5]
			end
			if (idx == `ULSR_IDX_TEST) begin
				test_q <= pwdata[8:0];
			end
		end
	end

	// ---------------------------------------------------------------
	// Frame number capture
	// ---------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_q <= 11'h000;
		end else if (link_sof) begin
			frame_q <= link_sof_frame; // [R4]
		end
	end

	// ---------------------------------------------------------------
	// Speed selection on bus reset
	// ---------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			speed_hs_q <= 1'b0;
			chirp_q <= 1'b0;
		end else if (link_bus_reset) begin
			// With both locks set, full speed wins.
			if (test_q[`ULSR_TEST_FS_LOCK]) begin
				speed_hs_q <= 1'b0; // [R7]
				chirp_q <= 1'b0;
			end else if (test_q[`ULSR_TEST_HS_LOCK]) begin
				speed_hs_q <= 1'b1; // [R8]
				chirp_q <= 1'b0;
			end else begin
				speed_hs_q <= 1'b0;
				chirp_q <= 1'b1;
			end
		end else if (chirp_q && link_chirp_done) begin
			speed_hs_q <= link_chirp_hs;
			chirp_q <= 1'b0;
		end
	end

	assign speed_hs = speed_hs_q;
	assign chirp_enable = chirp_q;

	// ---------------------------------------------------------------
	// Line state and NAK test modes
	// ---------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_j_q <= 1'b0;
			line_k_q <= 1'b0;
			nak_q <= 1'b0;
		end else begin
			// K wins when both line state bits are set.
			line_k_q <= test_q[`ULSR_TEST_K]; // [R12]
			line_j_q <= test_q[`ULSR_TEST_J] &&
				!test_q[`ULSR_TEST_K]; // [R13]
			nak_q <= link_in_token && test_q[`ULSR_TEST_NAK]; // [R14]
		end
	end

	assign line_j = line_j_q;
	assign line_k = line_k_q;
	assign nak_resp = nak_q;

	// ---------------------------------------------------------------
	// Endpoint bank and test packet sender
	// ---------------------------------------------------------------
	// Software banked writes land only for endpoints 1 to 11; receive count writes land for any rx_count_ep.
	ulsr_ep_bank u_bank (
		.pclk(pclk),
		.presetn(presetn),
		.sw_we(wr_acc && bank_hit && ep_valid),
		.sw_ep(select_q[3:0]),
		.sw_slot(slot[2:0]),
		.sw_wdata(pwdata[15:0]),
		.sw_rdata(bank_rdata),
		.hw_we(rx_count_we),
		.hw_ep(rx_count_ep),
		.hw_count(rx_count)
	);

	// The buffer is expected loaded and armed before the mode bit. [R9]
	ulsr_test_tx u_test (
		.pclk(pclk),
		.presetn(presetn),
		.enable(test_q[`ULSR_TEST_PACKET]), // [R11]
		.ep0_rd_data(ep0_rd_data),
		.ep0_rd_addr(ep0_rd_addr),
		.tx_valid(tx_valid),
		.tx_ready(tx_ready),
		.tx_data(tx_data)
	);

endmodule // ulsr_top

// file: dv/ulsr_checker.sv
// Port assertions for the link event and test mode slice.
`timescale 1ns/1ns
`include "ulsr_defines.vh"
module ulsr_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`ULSR_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic link_suspended,
	input wire logic link_bus_reset,
	input wire logic link_chirp_done,
	input wire logic link_in_token,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic [7:0] tx_data,
	input wire logic speed_hs,
	input wire logic nak_resp,
	input wire logic line_j,
	input wire logic line_k
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire rs = psel && !penable && !pwrite;
	wire tw = psel && penable && pwrite && paddr == 12'h03C;
	property p_susp;
		rs && paddr == 12'h028 |=> prdata[0] == $past(link_suspended);
	endproperty
	a_susp: assert property (p_susp) else $error("suspend bit wrong");
	property p_frame;
		rs && paddr == 12'h030 |=> prdata[31:11] == 21'h000000;
	endproperty
	a_frame: assert property (p_frame) else $error("frame high bits");
	property p_hs;
		$rose(speed_hs) |-> $past(link_bus_reset) || $past(link_chirp_done);
	endproperty
	a_hs: assert property (p_hs) else $error("speed rose alone");
	property p_pid;
		$rose(tx_valid) |-> tx_data == 8'hC3;
	endproperty
	a_pid: assert property (p_pid) else $error("packet start wrong");
	property p_hold;
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
	endproperty
	a_hold: assert property (p_hold) else $error("byte not held");
	property p_k;
		tw && pwdata[2] |-> ##[1:2] line_k;
	endproperty
	a_k: assert property (p_k) else $error("k state missing");
	property p_j;
		tw && pwdata[1] && !pwdata[2] |-> ##[1:2] line_j;
	endproperty
	a_j: assert property (p_j) else $error("j state missing");
	property p_nak;
		nak_resp |-> $past(link_in_token);
	endproperty
	a_nak: assert property (p_nak) else $error("nak without token");
endmodule // ulsr_checker

bind ulsr_top ulsr_checker u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .link_suspended(link_suspended),
	.link_bus_reset(link_bus_reset), .link_chirp_done(link_chirp_done),
	.link_in_token(link_in_token), .tx_valid(tx_valid),
	.tx_ready(tx_ready), .tx_data(tx_data), .speed_hs(speed_hs),
	.nak_resp(nak_resp), .line_j(line_j), .line_k(line_k));

// file: dv/ulsr_host_model.sv
// Host side model: link event pulses and a stalling test byte sink.
`timescale 1ns/1ns
module ulsr_host_model (
	input wire logic pclk,
	output logic link_suspended,
	output wire logic link_resume_det,
	output wire logic link_bus_reset,
	output wire logic link_sof,
	output logic [10:0] link_sof_frame,
	output wire logic link_chirp_done,
	output logic link_chirp_hs,
	output wire logic link_in_token,
	output logic tx_ready
);
	logic [4:0] ev_q = 5'h00;
	// Event codes: 0 resume, 1 bus reset, 2 SOF, 3 IN token, 4 chirp done.
	assign {link_chirp_done, link_in_token, link_sof, link_bus_reset,
		link_resume_det} = ev_q;
	initial begin
		link_suspended = 1'b0;
		link_sof_frame = 11'h000;
		link_chirp_hs = 1'b0;
		tx_ready = 1'b0;
	end
	// The sink stalls at random so the sender must hold each byte.
	always @(posedge pclk) begin
		tx_ready <= 1'($urandom_range(1, 0));
	end
	// Sends a one-cycle event; the frame lines carry garbage afterwards.
	task automatic ev(input int k, input logic [10:0] f);
		@(posedge pclk);
		ev_q <= 5'(5'h01 << k);
		link_sof_frame <= f;
		link_chirp_hs <= f[0];
		@(posedge pclk);
		ev_q <= 5'h00;
		link_sof_frame <= ~f;
		link_chirp_hs <= ~f[0];
		@(posedge pclk);
		#1;
	endtask
	task automatic susp(input logic v);
		@(posedge pclk);
		link_suspended <= v;
	endtask
endmodule // ulsr_host_model

// file: dv/ulsr_tb.sv
// Self-checking bench for the link event and test mode slice.
`timescale 1ns/1ns
module testbench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic rx_count_we = 1'b0;
	logic [3:0] rx_count_ep = 4'h0;
	logic [15:0] rx_count = 16'h0;
	wire [31:0] prdata;
	wire [10:0] link_sof_frame;
	wire [7:0] ep0_rd_data, tx_data;
	wire [5:0] ep0_rd_addr;
	wire pready, pslverr, link_suspended, link_resume_det, link_bus_reset;
	wire link_sof, link_chirp_done, link_chirp_hs, link_in_token, tx_ready;
	wire tx_valid, sig_irq, speed_hs, chirp_enable, nak_resp, line_j, line_k;
	int fails = 0;
	int samples_checked = 0;
	int naks = 0;
	int eps[4] = '{1, 11, 0, 12};
	logic [15:0] dv[4];
	logic [31:0] rq[$];
	logic [7:0] bq[$];
	// The endpoint 0 buffer holds a fixed pattern from time zero.
	assign ep0_rd_data = {2'b01, ep0_rd_addr} ^ 8'hA5;
	ulsr_top u_ulsr_top (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.tx_data(tx_data),
		.link_suspended(link_suspended), .link_resume_det(link_resume_det),
		.link_bus_reset(link_bus_reset), .link_sof(link_sof),
		.link_sof_frame(link_sof_frame), .link_chirp_done(link_chirp_done),
		.link_chirp_hs(link_chirp_hs), .link_in_token(link_in_token),
		.rx_count_we(rx_count_we), .rx_count_ep(rx_count_ep),
		.rx_count(rx_count), .ep0_rd_data(ep0_rd_data),
		.ep0_rd_addr(ep0_rd_addr), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.sig_irq(sig_irq), .speed_hs(speed_hs), .chirp_enable(chirp_enable),
		.nak_resp(nak_resp), .line_j(line_j), .line_k(line_k));
	ulsr_host_model u_ulsr_host_model (.pclk(pclk),
		.link_suspended(link_suspended), .link_resume_det(link_resume_det),
		.link_bus_reset(link_bus_reset), .link_sof(link_sof),
		.link_sof_frame(link_sof_frame), .link_chirp_done(link_chirp_done),
		.link_chirp_hs(link_chirp_hs), .link_in_token(link_in_token),
		.tx_ready(tx_ready));
	initial begin
		forever #20 pclk = ~pclk;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		rq.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic ev(input int k, input logic [10:0] f);
		u_ulsr_host_model.ev(k, f);
	endtask
	// Queues one test packet: PID, pattern, inverted CRC low byte first.
	task automatic pkt;
		logic [15:0] c;
		logic [7:0] b;
		c = 16'hFFFF;
		bq.push_back(8'hC3);
		for (int i = 0; i < 53; i++) begin
			b = {2'b01, 6'(i)} ^ 8'hA5;
			bq.push_back(b);
			for (int j = 0; j < 8; j++)
				c = (c[0] ^ b[j]) ? (c >> 1) ^ 16'hA001 : c >> 1;
		end
		bq.push_back(~c[7:0]);
		bq.push_back(~c[15:8]);
	endtask
	task automatic finish_test;
		$display("Checks %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite)
			chk(prdata, rq.size() ? rq.pop_front() : 'x);
		if (psel && penable && pready === 1'b1)
			chk(pslverr, !(paddr inside {12'h028, 12'h02C, 12'h030,
				12'h038, 12'h03C, 12'h040, 12'h048, 12'h04C, 12'h050,
				12'h058, 12'h05C, 12'h060}));
		if (tx_valid === 1'b1 && tx_ready)
			chk(tx_data, bq.size() ? bq.pop_front() : 'x);
		if (nak_resp === 1'b1)
			naks++;
	end
	initial begin
		#(40 * 20000);
		fails++;
		finish_test;
	end
	initial begin
		logic [10:0] f;
		logic [15:0] d;
		void'($urandom(85));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rd(12'h02C, 32'h006);
		rd(12'h038, 32'h0);
		rd(12'h03C, 32'h0);
		rd(12'h004, 32'h0);
		f = 11'($urandom);
		ev(2, f);
		chk(sig_irq, 1'b0);
		rd(12'h030, {21'h0, f});
		rd(12'h028, 32'h8);
		apb(1'b1, 12'h02C, 32'h8);
		ev(2, ~f);
		chk(sig_irq, 1'b1);
		rd(12'h02C, 32'h8);
		rd(12'h028, 32'h8);
		ev(0, 0);
		rd(12'h028, 32'h0);
		u_ulsr_host_model.susp(1'b1);
		ev(0, 0);
		rd(12'h028, 32'h3);
		u_ulsr_host_model.susp(1'b0);
		apb(1'b1, 12'h03C, 32'h10);
		ev(1, 0);
		chk({chirp_enable, speed_hs}, 32'h1);
		apb(1'b1, 12'h03C, 32'h20);
		ev(1, 0);
		chk({chirp_enable, speed_hs}, 32'h0);
		apb(1'b1, 12'h03C, 32'h0);
		ev(1, 0);
		chk({chirp_enable, speed_hs}, 32'h2);
		ev(4, 1);
		chk({chirp_enable, speed_hs}, 32'h1);
		rd(12'h028, 32'h4);
		ev(3, 0);
		apb(1'b1, 12'h03C, 32'h1);
		ev(3, 0);
		chk(naks, 32'h1);
		apb(1'b1, 12'h03C, 32'h2);
		@(posedge pclk);
		#1;
		chk({line_k, line_j}, 32'h1);
		apb(1'b1, 12'h03C, 32'h4);
		@(posedge pclk);
		#1;
		chk({line_k, line_j}, 32'h2);
		apb(1'b1, 12'h03C, 32'h0);
		foreach (eps[i]) begin
			dv[i] = 16'($urandom);
			apb(1'b1, 12'h038, eps[i]);
			apb(1'b1, 12'h040, dv[i]);
		end
		foreach (eps[i]) begin
			apb(1'b1, 12'h038, eps[i]);
			rd(12'h038, eps[i]);
			rd(12'h040, (eps[i] inside {[1:11]}) ? dv[i] : 0);
		end
		d = 16'($urandom);
		rx_count_we <= 1'b1;
		rx_count_ep <= 4'hB;
		rx_count <= d;
		@(posedge pclk);
		rx_count_we <= 1'b0;
		apb(1'b1, 12'h038, 32'hB);
		apb(1'b1, 12'h060, 32'h0);
		rd(12'h060, d);
		pkt;
		pkt;
		apb(1'b1, 12'h03C, 32'h8);
		while (bq.size() > 40) @(posedge pclk);
		apb(1'b1, 12'h03C, 32'h0);
		while (bq.size() > 0) @(posedge pclk);
		repeat (2) @(posedge pclk);
		#1;
		chk(tx_valid, 1'b0);
		finish_test;
	end
endmodule // testbench
